//--- cmoi_pkg.sv
// Shared constants, register map and frame carriers for the message-object and interrupt block
package cmoi_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_OBJ = 32;
   localparam int STD_ID_W = 11;
   localparam int EXT_ID_W = 29;
   localparam int MAX_BYTES = 8;
   localparam int DLC_W = 4;
   localparam logic [5:0] OBJ_NUM_MAX = 6'h20;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CAUSE = 8'h08;
   localparam logic [7:0] REG_PEND_MAP = 8'h0C;
   localparam logic [7:0] REG_TXPEND_MAP = 8'h10;
   localparam logic [7:0] REG_UNREAD_DATA_BIT_MAP = 8'h14;
   localparam logic [7:0] REG_VALID_MAP = 8'h18;
   localparam logic [7:0] REG_COMMAND = 8'h20;
   localparam logic [7:0] REG_STG_ID = 8'h24;
   localparam logic [7:0] REG_STG_MASK = 8'h28;
   localparam logic [7:0] REG_STG_CFG = 8'h2C;
   localparam logic [7:0] REG_STG_DATA_LO = 8'h30;
   localparam logic [7:0] REG_STG_DATA_HI = 8'h34;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_MASTER_BIT = 0;
   localparam int CTRL_ERR_BIT = 1;
   localparam int CTRL_STATUS_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   localparam int STS_BUSOFF_BIT = 0;
   localparam int STS_EWARN_BIT = 1;
   localparam int STS_RXOK_BIT = 2;
   localparam int STS_TXOK_BIT = 3;
   localparam int STS_BUSERR_BIT = 4;

   localparam logic [31:0] STATUS_CAUSE_CODE = 32'h0000_8000;

   localparam int CMD_SET_BIT = 8;
   localparam int CMD_GET_BIT = 9;
   localparam int CMD_GET_CLRPEND_BIT = 10;
   localparam int CMD_CLEAR_BIT = 11;
   localparam int CMD_IRQCLR_BIT = 12;
   localparam int CMD_TXREQ_BIT = 13;

   localparam int ID_EXT_BIT = 29;
   localparam int ID_FILT_BIT = 30;

   localparam int CFG_TXIE_BIT = 4;
   localparam int CFG_RXIE_BIT = 5;
   localparam int CFG_DLC_LSB = 8;
   localparam int CFG_UNREAD_DATA_BIT_BIT = 16;
   localparam int CFG_OVERRUN_BIT = 17;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ROLE_TRANSMIT,
      ROLE_TRANSMIT_REMOTE_REQ,
      ROLE_RECEIVE,
      ROLE_RECEIVE_REMOTE_REQ,
      ROLE_AUTO_ANSWER_REMOTE
   } cmoi_role_t;

   typedef struct packed {
      logic [EXT_ID_W-1:0] id;
      logic ext;
      logic remote;
      logic [DLC_W-1:0] dlc;
      logic [8*MAX_BYTES-1:0] data;
   } cmoi_frame_t;

   typedef struct packed {
      logic [EXT_ID_W-1:0] id;
      logic [EXT_ID_W-1:0] mask;
      logic ext;
      logic filt;
      cmoi_role_t role;
      logic txIe;
      logic rxIe;
      logic [DLC_W-1:0] dlc;
   } cmoi_obj_t;

endpackage

//--- cmoi_prio_enc.sv
// Priority encoder: lowest set request bit wins
`timescale 1ns/100ps
module cmoi_prio_enc (
   input wire logic [31:0] req,
   output logic found,
   output logic [4:0] index
);

   // Scan downward so the lowest index is the last to overwrite
   always_comb
   begin
      found = 1'b0;
      index = 5'h00;
      for (int i = 31; i >= 0; i--)
      begin
         if (req[i])
         begin
            found = 1'b1;
            index = 5'(i);
         end
      end
   end

endmodule

//--- cmoi_core.sv
// Message objects, acceptance filtering and interrupt gating of the CAN controller
//
// Functional notes
// - Only individually enabled sources raise interrupt
// - Global enable gates every interrupt request
// - Object transfer interrupts need object enable
// - Error interrupt on bus-off or warning
// - Status interrupt on transfer or bus error
// - Cause register and pending bitmap readable
// - Cause gives status code or object number
// - Status register read clears status interrupt
// - Clear command or readout with clear-pending bit clears object pending
// - Pending bitmap, one bit per object
// - Thirty-two objects numbered one to thirty-two
// - Invalidated object stays silent and quiet
// - New-data flag set on store, cleared on read
// - Overrun flag when unread data overwritten
// - Five object roles supported
// - Standard or extended identifier per object
// - Masked identifier compare when filter enabled
// - Separate transmit and receive interrupt enables
// - Eight byte payload with length field
// - Configuration write replaces whole definition
// - Transmit-pending, new-data and valid bitmaps
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module cmoi_core (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire cmoi_pkg::cmoi_frame_t rxFrame,
   input wire logic rxValid,
   input wire logic rxOkEvent,
   input wire logic busErrEvent,
   input wire logic busOffLevel,
   input wire logic errWarnLevel,
   input wire logic txDoneEvent,
   input wire logic [4:0] txDoneIndex,
   output cmoi_pkg::cmoi_frame_t txFrame,
   output logic txValid,
   output logic [4:0] txObjIndex,
   output logic irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // One-hot vector for an object index, empty when not enabled
   function automatic logic [31:0] objHot(input logic [4:0] idx, input logic en);
      logic [31:0] v;
      v = 32'h0000_0001 << idx;
      return en ? v : 32'h0000_0000;
   endfunction

   // Identifier compare; standard frames compare only the low bits
   function automatic logic idMatch(input cmoi_pkg::cmoi_obj_t o, input cmoi_pkg::cmoi_frame_t f);
      logic [cmoi_pkg::EXT_ID_W-1:0] sel;
      logic [cmoi_pkg::EXT_ID_W-1:0] diff;
      sel = o.filt ? o.mask : {cmoi_pkg::EXT_ID_W{1'b1}};
      if (!o.ext)
         sel = sel & {{(cmoi_pkg::EXT_ID_W-cmoi_pkg::STD_ID_W){1'b0}}, {cmoi_pkg::STD_ID_W{1'b1}}};
      diff = (o.id ^ f.id) & sel;
      return (o.ext == f.ext) && (diff == '0);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cmoi_pkg::cmoi_obj_t obj_q [cmoi_pkg::NUM_OBJ];
   logic [63:0] objData_q [cmoi_pkg::NUM_OBJ];
   logic [31:0] valid_q, valid_d;
   logic [31:0] txPend_q, txPend_d;
   logic [31:0] unread_data_bit_q, unread_data_bit_d;
   logic [31:0] over_q, over_d;
   logic [31:0] pend_q, pend_d;
   logic [2:0] ctrl_q;
   logic stsRxOk_q, stsTxOk_q, stsBusErr_q;
   logic statusPend_q, errPend_q;
   logic busOffPrev_q, errWarnPrev_q;
   cmoi_pkg::cmoi_obj_t stgObj_q;
   logic [63:0] stgData_q;
   logic stgNewDat_q, stgOver_q;
   logic [31:0] rdMux;
   logic [31:0] rdData_q;
   cmoi_pkg::cmoi_frame_t txFrame_q;
   logic txValid_q;
   logic [4:0] txObjIndex_q;
   logic irq_q;

   // ----------------------------------------------------------------
   // Register strobes and command decode
   // ----------------------------------------------------------------
   wire wrCtrl = regWrite && (regAddr == cmoi_pkg::REG_CTRL);
   wire wrCmd = regWrite && (regAddr == cmoi_pkg::REG_COMMAND);
   wire rdStatus = regRead && (regAddr == cmoi_pkg::REG_STATUS);
   wire [5:0] cmdNum = regWrData[5:0];
   wire cmdOk = wrCmd && (cmdNum != 6'h00) && (cmdNum <= cmoi_pkg::OBJ_NUM_MAX);
   wire [5:0] cmdNumM1 = cmdNum - 6'h01;
   wire [4:0] cmdIdx = cmdNumM1[4:0];
   wire [31:0] setHot = objHot(cmdIdx, cmdOk && regWrData[cmoi_pkg::CMD_SET_BIT]);
   wire [31:0] getHot = objHot(cmdIdx, cmdOk && regWrData[cmoi_pkg::CMD_GET_BIT]);
   wire [31:0] getClrHot = getHot & {32{regWrData[cmoi_pkg::CMD_GET_CLRPEND_BIT]}};
   wire [31:0] clrHot = objHot(cmdIdx, cmdOk && regWrData[cmoi_pkg::CMD_CLEAR_BIT]);
   wire [31:0] irqClrHot = objHot(cmdIdx, cmdOk && regWrData[cmoi_pkg::CMD_IRQCLR_BIT]);
   wire [31:0] txReqHot = objHot(cmdIdx, cmdOk && regWrData[cmoi_pkg::CMD_TXREQ_BIT]) & valid_q;
   // Number zero with the interrupt-clear bit drops the status cause
   wire cmdStsClr = wrCmd && (cmdNum == 6'h00) && regWrData[cmoi_pkg::CMD_IRQCLR_BIT];
   wire setTxRole = (stgObj_q.role == cmoi_pkg::ROLE_TRANSMIT) ||
                    (stgObj_q.role == cmoi_pkg::ROLE_TRANSMIT_REMOTE_REQ);

   // ----------------------------------------------------------------
   // Receive acceptance
   // ----------------------------------------------------------------
   logic [31:0] rxHit;
   logic rxFound;
   logic [4:0] rxIdx;

   // Each valid object checks role against frame kind and identifier
   genvar g;
   generate
      for (g = 0; g < cmoi_pkg::NUM_OBJ; g++)
      begin : gAccept
         wire cmoi_pkg::cmoi_role_t r = obj_q[g].role;
         wire roleOk = rxFrame.remote ?
            ((r == cmoi_pkg::ROLE_RECEIVE_REMOTE_REQ) || (r == cmoi_pkg::ROLE_AUTO_ANSWER_REMOTE)) :
            ((r == cmoi_pkg::ROLE_RECEIVE) || (r == cmoi_pkg::ROLE_TRANSMIT_REMOTE_REQ));
         assign rxHit[g] = rxValid && valid_q[g] && roleOk && idMatch(obj_q[g], rxFrame);
      end
   endgenerate

   // Several objects may match; the lowest number takes the frame
   cmoi_prio_enc uRxSel (
      .req(rxHit),
      .found(rxFound),
      .index(rxIdx)
   );

   wire cmoi_pkg::cmoi_obj_t rxObj = obj_q[rxIdx];
   wire [31:0] rxHot = objHot(rxIdx, rxFound);
   wire [31:0] rxDataHot = rxHot & {32{!rxFrame.remote}};
   wire [31:0] autoAnsHot = rxHot & {32{rxFrame.remote && (rxObj.role == cmoi_pkg::ROLE_AUTO_ANSWER_REMOTE)}};
   wire [31:0] remReqHot = rxHot & {32{rxFrame.remote && (rxObj.role == cmoi_pkg::ROLE_RECEIVE_REMOTE_REQ)}};
   wire [31:0] newDatSet = rxDataHot | remReqHot;
   wire [31:0] rxIrqHot = newDatSet & {32{rxObj.rxIe}};

   // ----------------------------------------------------------------
   // Transmit completion
   // ----------------------------------------------------------------
   wire [31:0] txDoneHot = objHot(txDoneIndex, txDoneEvent && txPend_q[txDoneIndex]);
   wire [31:0] txIrqHot = txDoneHot & {32{obj_q[txDoneIndex].txIe}};

   // ----------------------------------------------------------------
   // Per-object flag vectors
   // ----------------------------------------------------------------
   // Hardware sets beat software clears, except invalidation which silences the object
   always_comb
   begin
      valid_d = (valid_q | setHot) & ~clrHot;
      // transmit and answer roles arm transmission
      txPend_d = (txPend_q & ~(txDoneHot | rxDataHot | setHot | clrHot)) |
                 (((setHot & {32{setTxRole}}) | autoAnsHot | txReqHot) & ~clrHot);
      // new data set wins over read
      unread_data_bit_d = (unread_data_bit_q & ~(getHot | setHot | clrHot)) | (newDatSet & ~clrHot);
      over_d = (over_q & ~(getHot | setHot | clrHot)) | (newDatSet & unread_data_bit_q & ~clrHot);
      pend_d = (pend_q & ~(getClrHot | irqClrHot | setHot | clrHot)) | ((rxIrqHot | txIrqHot) & ~clrHot);
   end

   // Flag vectors restart empty: nothing valid, nothing pending
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         valid_q <= 32'h0000_0000;
         txPend_q <= 32'h0000_0000;
         unread_data_bit_q <= 32'h0000_0000;
         over_q <= 32'h0000_0000;
         pend_q <= 32'h0000_0000;
      end
      else
      begin
         valid_q <= valid_d;
         txPend_q <= txPend_d;
         unread_data_bit_q <= unread_data_bit_d;
         over_q <= over_d;
         pend_q <= pend_d;
      end
   end

   // Object storage carries no reset; the valid vector hides stale contents
   always_ff @(posedge clk)
   begin
      if (setHot != 32'h0000_0000)
      begin
         obj_q[cmdIdx] <= stgObj_q;
         objData_q[cmdIdx] <= stgData_q;
      end
      if (rxDataHot != 32'h0000_0000)
      begin
         obj_q[rxIdx].id <= rxFrame.id;
         obj_q[rxIdx].dlc <= rxFrame.dlc;
         objData_q[rxIdx] <= rxFrame.data;
      end
   end

   // ----------------------------------------------------------------
   // Controller status and causes
   // ----------------------------------------------------------------
   wire busOffRise = busOffLevel && !busOffPrev_q;
   wire errWarnRise = errWarnLevel && !errWarnPrev_q;
   wire stsEvent = rxOkEvent || txDoneEvent || busErrEvent;

   // Sticky status bits; a read clears them but a same-cycle event survives
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= cmoi_pkg::CTRL_RESET;
         stsRxOk_q <= 1'b0;
         stsTxOk_q <= 1'b0;
         stsBusErr_q <= 1'b0;
         statusPend_q <= 1'b0;
         errPend_q <= 1'b0;
         busOffPrev_q <= 1'b0;
         errWarnPrev_q <= 1'b0;
      end
      else
      begin
         if (wrCtrl)
            ctrl_q <= regWrData[2:0];
         busOffPrev_q <= busOffLevel;
         errWarnPrev_q <= errWarnLevel;
         stsRxOk_q <= (stsRxOk_q && !rdStatus) || rxOkEvent;
         stsTxOk_q <= (stsTxOk_q && !rdStatus) || txDoneEvent;
         stsBusErr_q <= (stsBusErr_q && !rdStatus) || busErrEvent;
         statusPend_q <= (statusPend_q && !rdStatus && !cmdStsClr) || stsEvent;
         errPend_q <= (errPend_q && !rdStatus && !cmdStsClr) || busOffRise || errWarnRise;
      end
   end

   wire masterEn = ctrl_q[cmoi_pkg::CTRL_MASTER_BIT];
   wire errSrc = errPend_q && ctrl_q[cmoi_pkg::CTRL_ERR_BIT];
   wire stsSrc = statusPend_q && ctrl_q[cmoi_pkg::CTRL_STATUS_BIT];
   logic pendFound;
   logic [4:0] pendIdx;

   // Cause register names the lowest pending object when no enabled error or status cause is pending
   cmoi_prio_enc uPendSel (
      .req(pend_q),
      .found(pendFound),
      .index(pendIdx)
   );

   wire [5:0] pendNum = {1'b0, pendIdx} + 6'h01;
   wire [31:0] causeVal = (errSrc || stsSrc) ? cmoi_pkg::STATUS_CAUSE_CODE :
                          pendFound ? {26'h0000000, pendNum} : 32'h0000_0000;

   // ----------------------------------------------------------------
   // Staging registers for object define and readout
   // ----------------------------------------------------------------
   // Software fills these before a define; a readout refills them from the object
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stgObj_q <= '0;
         stgData_q <= 64'h0000_0000_0000_0000;
         stgNewDat_q <= 1'b0;
         stgOver_q <= 1'b0;
      end
      else if (getHot != 32'h0000_0000)
      begin
         stgObj_q <= obj_q[cmdIdx];
         stgData_q <= objData_q[cmdIdx];
         stgNewDat_q <= unread_data_bit_q[cmdIdx];
         stgOver_q <= over_q[cmdIdx];
      end
      else if (regWrite)
      begin
         if (regAddr == cmoi_pkg::REG_STG_ID)
         begin
            stgObj_q.id <= regWrData[28:0];
            stgObj_q.ext <= regWrData[cmoi_pkg::ID_EXT_BIT];
            stgObj_q.filt <= regWrData[cmoi_pkg::ID_FILT_BIT];
         end
         else if (regAddr == cmoi_pkg::REG_STG_MASK)
            stgObj_q.mask <= regWrData[28:0];
         else if (regAddr == cmoi_pkg::REG_STG_CFG)
         begin
            stgObj_q.role <= cmoi_pkg::cmoi_role_t'(regWrData[2:0]);
            stgObj_q.txIe <= regWrData[cmoi_pkg::CFG_TXIE_BIT];
            stgObj_q.rxIe <= regWrData[cmoi_pkg::CFG_RXIE_BIT];
            stgObj_q.dlc <= regWrData[11:8];
         end
         else if (regAddr == cmoi_pkg::REG_STG_DATA_LO)
            stgData_q[31:0] <= regWrData;
         else if (regAddr == cmoi_pkg::REG_STG_DATA_HI)
            stgData_q[63:32] <= regWrData;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped offsets and reserved bits read as zero
   always_comb
   begin
      rdMux = 32'h0000_0000;
      if (regAddr == cmoi_pkg::REG_CTRL)
         rdMux = {29'h00000000, ctrl_q};
      else if (regAddr == cmoi_pkg::REG_STATUS)
      begin
         rdMux[cmoi_pkg::STS_BUSOFF_BIT] = busOffLevel;
         rdMux[cmoi_pkg::STS_EWARN_BIT] = errWarnLevel;
         rdMux[cmoi_pkg::STS_RXOK_BIT] = stsRxOk_q;
         rdMux[cmoi_pkg::STS_TXOK_BIT] = stsTxOk_q;
         rdMux[cmoi_pkg::STS_BUSERR_BIT] = stsBusErr_q;
      end
      else if (regAddr == cmoi_pkg::REG_CAUSE)
         rdMux = causeVal;
      else if (regAddr == cmoi_pkg::REG_PEND_MAP)
         rdMux = pend_q;
      else if (regAddr == cmoi_pkg::REG_TXPEND_MAP)
         rdMux = txPend_q;
      else if (regAddr == cmoi_pkg::REG_UNREAD_DATA_BIT_MAP)
         rdMux = unread_data_bit_q;
      else if (regAddr == cmoi_pkg::REG_VALID_MAP)
         rdMux = valid_q;
      else if (regAddr == cmoi_pkg::REG_STG_ID)
         rdMux = {1'b0, stgObj_q.filt, stgObj_q.ext, stgObj_q.id};
      else if (regAddr == cmoi_pkg::REG_STG_MASK)
         rdMux = {3'h0, stgObj_q.mask};
      else if (regAddr == cmoi_pkg::REG_STG_CFG)
      begin
         rdMux[2:0] = stgObj_q.role;
         rdMux[cmoi_pkg::CFG_TXIE_BIT] = stgObj_q.txIe;
         rdMux[cmoi_pkg::CFG_RXIE_BIT] = stgObj_q.rxIe;
         rdMux[11:8] = stgObj_q.dlc;
         rdMux[cmoi_pkg::CFG_UNREAD_DATA_BIT_BIT] = stgNewDat_q;
         rdMux[cmoi_pkg::CFG_OVERRUN_BIT] = stgOver_q;
      end
      else if (regAddr == cmoi_pkg::REG_STG_DATA_LO)
         rdMux = stgData_q[31:0];
      else if (regAddr == cmoi_pkg::REG_STG_DATA_HI)
         rdMux = stgData_q[63:32];
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdData_q <= 32'h0000_0000;
      else
         rdData_q <= regRead ? rdMux : 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // Transmit offer
   // ----------------------------------------------------------------
   logic txFound;
   logic [4:0] txIdx;

   // Lowest-numbered armed object goes to the bus first
   cmoi_prio_enc uTxSel (
      .req(txPend_q & valid_q),
      .found(txFound),
      .index(txIdx)
   );

   // Offer is re-evaluated every cycle; the engine reports completion by index
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         txValid_q <= 1'b0;
         txObjIndex_q <= 5'h00;
         txFrame_q <= '0;
      end
      else
      begin
         txValid_q <= txFound;
         txObjIndex_q <= txIdx;
         txFrame_q.id <= obj_q[txIdx].id;
         txFrame_q.ext <= obj_q[txIdx].ext;
         // remote request role sends remote frame
         txFrame_q.remote <= (obj_q[txIdx].role == cmoi_pkg::ROLE_TRANSMIT_REMOTE_REQ);
         // Length carried even for remote frames
         txFrame_q.dlc <= obj_q[txIdx].dlc;
         txFrame_q.data <= objData_q[txIdx];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   // master enable over the per-source requests
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_q <= 1'b0;
      else
         irq_q <= masterEn && (errSrc || stsSrc || (pend_q != 32'h0000_0000));
   end

   assign regRdData = rdData_q;
   assign txFrame = txFrame_q;
   assign txValid = txValid_q;
   assign txObjIndex = txObjIndex_q;
   assign irq = irq_q;

endmodule

//--- cmoi_checker.sv
// Port-level assertions for the message-object and interrupt block
`timescale 1ns/100ps
module cmoi_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic rxValid,
   input wire logic busOffLevel,
   input wire logic txDoneEvent,
   input wire logic txValid,
   input wire logic irq
);
   logic masterQ;
   logic anyEvt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Mirror of the master enable, the one control field visible outside
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         masterQ <= 1'b0;
      else if (regWrite && regAddr == cmoi_pkg::REG_CTRL)
         masterQ <= regWrData[cmoi_pkg::CTRL_MASTER_BIT];
   end
   // Events that may raise the request, leaving out rxOkEvent, busErrEvent and errWarnLevel
   assign anyEvt = regWrite | rxValid | txDoneEvent | busOffLevel;
   rd_idle_zero_a: assert property (!$past(regRead) |-> regRdData == 32'h0000_0000)
      else $error("read data outside answer cycle");
   master_gate_a: assert property (irq |-> $past(masterQ))
      else $error("request without master enable");
   cause_range_a: assert property ($past(regRead && regAddr == cmoi_pkg::REG_CAUSE) |->
      regRdData == cmoi_pkg::STATUS_CAUSE_CODE || regRdData <= 32'h0000_0020) else $error("cause out of range");
   irq_hold_a: assert property (irq && !regWrite && !regRead && !$past(regWrite) && !$past(regRead) |=> irq)
      else $error("request dropped without access");
   irq_cause_a: assert property ($rose(irq) |-> $past(anyEvt, 2) || $past(anyEvt, 3))
      else $error("request rose without event");
   tx_stand_a: assert property (txValid && !txDoneEvent && !$past(txDoneEvent) && !$past(rxValid)
      && !regWrite && !$past(regWrite) |=> txValid) else $error("offer withdrawn");
   tx_rise_a: assert property ($rose(txValid) |-> $past(regWrite, 2) || $past(rxValid, 2))
      else $error("offer without arming");
   tx_drop_a: assert property ($fell(txValid) |-> $past(txDoneEvent || regWrite || rxValid, 2))
      else $error("offer dropped without cause");
endmodule

//--- cmoi_bus_node.sv
// Other node on the bus: injects frames and completes offered transmits
`timescale 1ns/100ps
module cmoi_bus_node (
   input wire logic clk,
   input wire logic txValid,
   input wire logic [4:0] txObjIndex,
   input wire cmoi_pkg::cmoi_frame_t txFrame,
   output cmoi_pkg::cmoi_frame_t rxFrame,
   output logic rxValid,
   output logic rxOkEvent,
   output logic txDoneEvent,
   output logic [4:0] txDoneIndex
);
   cmoi_pkg::cmoi_frame_t seen;
   logic [3:0] cnt = 4'h0;
   initial
   begin
      rxFrame = '0;
      rxValid = 1'b0;
      rxOkEvent = 1'b0;
      txDoneEvent = 1'b0;
      txDoneIndex = 5'h00;
   end
   // Idle lines carry the inverse so a stale frame never looks valid
   task send(input cmoi_pkg::cmoi_frame_t f);
      @(posedge clk);
      rxFrame <= f;
      rxValid <= 1'b1;
      rxOkEvent <= 1'b1;
      @(posedge clk);
      rxValid <= 1'b0;
      rxOkEvent <= 1'b0;
      rxFrame <= ~f;
   endtask
   // Fixed bus time of four cycles before the frame is on the wire
   always @(posedge clk)
   begin
      cnt <= (txValid && !txDoneEvent) ? cnt + 4'h1 : 4'h0;
      txDoneEvent <= txValid && cnt == 4'h4;
      txDoneIndex <= txValid ? txObjIndex : ~txDoneIndex;
      if (txValid && cnt == 4'h4)
         seen <= txFrame;
   end
endmodule

//--- testbench.sv
// Register-level test of the message-object and interrupt block
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0;
   logic resetn, regWrite, regRead, rxValid, rxOkEvent, txDoneEvent, txValid, irq, busOffLevel;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData;
   logic [4:0] txDoneIndex, txObjIndex;
   cmoi_pkg::cmoi_frame_t rxFrame, txFrame;
   int err_count = 0;
   int comparisons = 0;
   always #2 clk = ~clk;
   cmoi_core u_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .rxFrame(rxFrame), .rxValid(rxValid), .rxOkEvent(rxOkEvent),
      .busErrEvent(1'b0), .busOffLevel(busOffLevel), .errWarnLevel(1'b0), .txDoneEvent(txDoneEvent),
      .txDoneIndex(txDoneIndex), .txFrame(txFrame), .txValid(txValid), .txObjIndex(txObjIndex), .irq(irq));
   cmoi_bus_node u_node (.clk(clk), .txValid(txValid), .txObjIndex(txObjIndex), .txFrame(txFrame),
      .rxFrame(rxFrame), .rxValid(rxValid), .rxOkEvent(rxOkEvent), .txDoneEvent(txDoneEvent),
      .txDoneIndex(txDoneIndex));
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         $display("BAD %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask
   // One-cycle strobes, changed just after the edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), regRdData, e);
   endtask
   task def(input logic [5:0] n, input logic [31:0] id, input logic [31:0] m, input logic [31:0] c,
      input logic [31:0] lo);
      wr(8'h24, id);
      wr(8'h28, m);
      wr(8'h2C, c);
      wr(8'h30, lo);
      wr(8'h34, 32'h0000_0000);
      wr(8'h20, {24'h000001, 2'h0, n});
   endtask
   // Bounded wait on the request level; running out ends the run
   task waitIrq(input logic e);
      for (int i = 0; i < 50 && irq !== e; i++)
         @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
      if (irq !== e)
         final_report();
   endtask
   function automatic cmoi_pkg::cmoi_frame_t mk(input logic [28:0] id, input logic [63:0] d);
      mk = '{id: id, ext: 1'b0, remote: 1'b0, dlc: 4'h8, data: d};
   endfunction
   initial
   begin
      resetn = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      busOffLevel = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h18, 32'h0000_0000);
      def(6'h03, 32'h4000_0120, 32'h0000_07F0, 32'h0000_0822, 32'h0000_0000);
      rd(8'h18, 32'h0000_0004);
      u_node.send(mk(29'h12F, 64'h1));
      u_node.send(mk(29'h13F, 64'h2));
      u_node.send(mk(29'h12A, 64'h8877_6655_4433_2211));
      rd(8'h14, 32'h0000_0004);
      rd(8'h0C, 32'h0000_0004);
      rd(8'h08, 32'h0000_0003);
      chk("irq off", {31'h0, irq}, 32'h0);
      wr(8'h00, 32'h0000_0001);
      waitIrq(1'b1);
      wr(8'h20, 32'h0000_0603);
      rd(8'h2C, 32'h0003_0822);
      rd(8'h30, 32'h4433_2211);
      rd(8'h34, 32'h8877_6655);
      rd(8'h14, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      waitIrq(1'b0);
      $display("test receive done");
      def(6'h01, 32'h0000_0055, 32'h0000_0000, 32'h0000_0210, 32'h0000_BEEF);
      waitIrq(1'b1);
      rd(8'h10, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0001);
      chk("tx data", u_node.seen.data[31:0], 32'h0000_BEEF);
      chk("tx len", {28'h0, u_node.seen.dlc}, 32'h0000_0002);
      wr(8'h00, 32'h0000_0005);
      rd(8'h08, cmoi_pkg::STATUS_CAUSE_CODE);
      rd(8'h04, 32'h0000_000C);
      rd(8'h04, 32'h0000_0000);
      rd(8'h08, 32'h0000_0001);
      wr(8'h20, 32'h0000_1001);
      rd(8'h0C, 32'h0000_0000);
      waitIrq(1'b0);
      $display("test transmit done");
      wr(8'h00, 32'h0000_0003);
      busOffLevel <= 1'b1;
      waitIrq(1'b1);
      rd(8'h08, cmoi_pkg::STATUS_CAUSE_CODE);
      rd(8'h04, 32'h0000_0001);
      rd(8'h08, 32'h0000_0000);
      wr(8'h20, 32'h0000_0803);
      rd(8'h18, 32'h0000_0001);
      u_node.send(mk(29'h120, 64'h3));
      rd(8'h14, 32'h0000_0000);
      def(6'h05, 32'h0000_0077, 32'h0000_0000, 32'h0000_0104, 32'h0000_0000);
      u_node.send('{id: 29'h77, ext: 1'b0, remote: 1'b1, dlc: 4'h1, data: 64'h0});
      rd(8'h10, 32'h0000_0010);
      $display("test error and clear done");
      final_report();
   end
endmodule
bind cmoi_core cmoi_checker u_chk (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxValid(rxValid),
   .busOffLevel(busOffLevel), .txDoneEvent(txDoneEvent), .txValid(txValid), .irq(irq));
